// ### mct_capture_timer.sv
/*
 mct_capture_timer: twelve 16-bit up/down counters with input capture,
 overflow flags, interrupt and two two-channel cascades.
 Assumes a synchronous register master on ref_clk and asynchronous pins.
*/
// What this block does
// - after reset each counter is stopped, with no clearing source chosen
// - a counter counts only once its start bit is written to one
// - rollover from ffff to zero sets the channel overflow flag
// - an enabled overflow flag raises that channel's interrupt request
// - after overflow the counter keeps counting up from zero
// - the selected pin edge copies the counter into the general register
// - capture edge is rising only, falling only, or both
// - channels 0,1,3,4,6,7,9,10 may capture on another channel's clock or match
// - channels 0,3,6,9 never capture on an undivided source clock
// - cascaded capture puts upper half in channel 1, lower in channel 2
// - cascaded channel 1 counts up on channel 2 overflow, down on underflow
`timescale 1ns/100ps
`default_nettype none
module mct_capture_timer (
   input  wire logic         ref_clk,
   input  wire logic         rst_b,
   input  wire logic [7:0]   addr,
   input  wire logic [31:0]  wr_data,
   input  wire logic         wr_stb,
   input  wire logic         rd_stb,
   output logic [31:0]       rd_data,
   input  wire logic [11:0]  capture_compare_pin_a,
   input  wire logic [11:0]  capture_compare_pin_b,
   output logic [11:0]       ovf_irq,
   output logic              irq
);
   localparam int N = mct_pkg::CH_NUM;

   // -----------------------------------------------------------
   // decode helpers
   // -----------------------------------------------------------
   function automatic logic page_hit(input logic [7:0] a, input logic [1:0] page);
      page_hit = (a[7:6] == page) && (a[5:2] < 4'(N)) && (a[1:0] == 2'h0);
   endfunction : page_hit

   function automatic int src_of(input int c);
      src_of = (c % 3 == 0) ? c + 1 : c - 1;
   endfunction : src_of

   // -----------------------------------------------------------
   // pins and prescaler
   // -----------------------------------------------------------
   mct_pkg::mct_pin_t          pa_ev [N];
   mct_pkg::mct_pin_t          pb_ev [N];
   logic [mct_pkg::DIV_NUM-1:0] div_tick;

   for (genvar c = 0; c < N; c++)
   begin : g_pin
      mct_edge_det u_pa (
         .ref_clk (ref_clk),
         .rst_b   (rst_b),
         .pin_in  (capture_compare_pin_a[c]),
         .pin_ev  (pa_ev[c])
      );
      mct_edge_det u_pb (
         .ref_clk (ref_clk),
         .rst_b   (rst_b),
         .pin_in  (capture_compare_pin_b[c]),
         .pin_ev  (pb_ev[c])
      );
   end

   mct_prescale u_pre (
      .ref_clk  (ref_clk),
      .rst_b    (rst_b),
      .div_tick (div_tick)
   );

   // -----------------------------------------------------------
   // state
   // -----------------------------------------------------------
   mct_pkg::mct_ctrl_t ctrl_reg [N];
   mct_pkg::mct_ctrl_t ctrl_next [N];
   logic [15:0]        cnt_reg  [N];
   logic [15:0]        cnt_next [N];
   logic [15:0]        gen_reg  [N];
   logic [15:0]        gen_next [N];
   logic [11:0]        start_reg;
   logic [11:0]        start_next;
   logic [11:0]        ovf_flag_reg;
   logic [11:0]        ovf_flag_next;
   logic [11:0]        cap_flag_reg;
   logic [11:0]        cap_flag_next;
   logic [11:0]        ovf_en_reg;
   logic [11:0]        ovf_en_next;
   logic [11:0]        cap_en_reg;
   logic [11:0]        cap_en_next;
   logic [31:0]        rd_reg;
   logic [31:0]        rd_next;

   logic [11:0]        clk_tick;
   logic [11:0]        tick;
   logic [11:0]        up;
   logic [11:0]        ovf;
   logic [11:0]        unf;
   logic [11:0]        match;
   logic [11:0]        cap_evt;
   logic [11:0]        w1c_ovf;
   logic [11:0]        w1c_cap;

   // -----------------------------------------------------------
   // count ticks, direction, overflow
   // -----------------------------------------------------------
   always_comb
   begin
      for (int c = 0; c < N; c++)
      begin
         clk_tick[c] = (ctrl_reg[c].clk_sel == mct_pkg::CLK_STOP) ? 1'b0
                       : div_tick[ctrl_reg[c].clk_sel];
         // phase counting: A edges step, A edge type xor B level picks direction
         if (ctrl_reg[c].phase_mode)
         begin
            tick[c] = start_reg[c] & (pa_ev[c].rise | pa_ev[c].fall);
            up[c]   = pa_ev[c].rise ^ pb_ev[c].level;
         end
         else
         begin
            tick[c] = start_reg[c] & clk_tick[c];
            up[c]   = 1'b1;
         end
      end
      // the cascade source is never itself cascaded, so one pass suffices
      for (int c = 0; c < N; c++)
      begin
         if (mct_pkg::CASCADE_MASK[c] && ctrl_reg[c].cascade)
         begin
            tick[c] = start_reg[c] & (ovf_of(c + 1) | unf_of(c + 1));
            up[c]   = ovf_of(c + 1);
         end
      end
      for (int c = 0; c < N; c++)
      begin
         ovf[c]   = tick[c] & up[c] & (cnt_reg[c] == mct_pkg::CNT_MAX);
         unf[c]   = tick[c] & ~up[c] & (cnt_reg[c] == mct_pkg::CNT_RST);
         match[c] = tick[c] & (cnt_reg[c] == gen_reg[c]);
      end
   end

   function automatic logic ovf_of(input int s);
      ovf_of = tick_base(s) & up_base(s) & (cnt_reg[s] == mct_pkg::CNT_MAX);
   endfunction : ovf_of

   function automatic logic unf_of(input int s);
      unf_of = tick_base(s) & ~up_base(s) & (cnt_reg[s] == mct_pkg::CNT_RST);
   endfunction : unf_of

   function automatic logic tick_base(input int s);
      tick_base = ctrl_reg[s].phase_mode ? start_reg[s] & (pa_ev[s].rise | pa_ev[s].fall)
                  : start_reg[s] & (ctrl_reg[s].clk_sel != mct_pkg::CLK_STOP)
                    & div_tick[ctrl_reg[s].clk_sel];
   endfunction : tick_base

   function automatic logic up_base(input int s);
      up_base = ctrl_reg[s].phase_mode ? pa_ev[s].rise ^ pb_ev[s].level : 1'b1;
   endfunction : up_base

   // -----------------------------------------------------------
   // capture events
   // -----------------------------------------------------------
   always_comb
   begin
      for (int c = 0; c < N; c++)
      begin
         int s;
         s = src_of(c);
         cap_evt[c] = 1'b0;
         case (ctrl_reg[c].cap_src)
            mct_pkg::SRC_PIN:
               case (ctrl_reg[c].edge_sel)
                  mct_pkg::EDGE_RISE: cap_evt[c] = pa_ev[c].rise;
                  mct_pkg::EDGE_FALL: cap_evt[c] = pa_ev[c].fall;
                  mct_pkg::EDGE_BOTH: cap_evt[c] = pa_ev[c].rise | pa_ev[c].fall;
                  default:            cap_evt[c] = 1'b0;
               endcase
            mct_pkg::SRC_CLK:
               cap_evt[c] = mct_pkg::CAP_OTHER_MASK[c] & clk_tick[s]
                            & ~(mct_pkg::PHI1_BLOCK_MASK[c]
                                & (ctrl_reg[s].clk_sel == mct_pkg::CLK_DIV1));
            mct_pkg::SRC_MATCH:
               cap_evt[c] = mct_pkg::CAP_OTHER_MASK[c] & match[s];
            default:
               cap_evt[c] = 1'b0;
         endcase
      end
   end

   // -----------------------------------------------------------
   // register port and next state
   // -----------------------------------------------------------
   always_comb
   begin
      start_next  = start_reg;
      ovf_en_next = ovf_en_reg;
      cap_en_next = cap_en_reg;
      w1c_ovf     = 12'h000;
      w1c_cap     = 12'h000;
      rd_next     = 32'h0000_0000;
      for (int c = 0; c < N; c++)
      begin
         ctrl_next[c] = ctrl_reg[c];
         gen_next[c]  = cap_evt[c] ? cnt_reg[c] : gen_reg[c];
         cnt_next[c]  = cnt_reg[c];
         if (tick[c])
            cnt_next[c] = up[c] ? cnt_reg[c] + 16'h0001
                                : cnt_reg[c] - 16'h0001;
         // clearing only when software picks it; reset value leaves it off
         if (ctrl_reg[c].clr_on_cap && cap_evt[c])
            cnt_next[c] = mct_pkg::CNT_RST;
      end
      if (wr_stb)
      begin
         if (addr == mct_pkg::ADDR_START)
            start_next = wr_data[11:0];
         if (addr == mct_pkg::ADDR_STATUS)
         begin
            w1c_ovf = wr_data[mct_pkg::STAT_OVF_LSB +: 12];
            w1c_cap = wr_data[mct_pkg::STAT_CAP_LSB +: 12];
         end
         if (addr == mct_pkg::ADDR_IRQEN)
         begin
            ovf_en_next = wr_data[mct_pkg::STAT_OVF_LSB +: 12];
            cap_en_next = wr_data[mct_pkg::STAT_CAP_LSB +: 12];
         end
         if (page_hit(addr, mct_pkg::PAGE_CTRL))
            ctrl_next[addr[5:2]] = mct_pkg::mct_ctrl_t'(wr_data[9:0]);
         if (page_hit(addr, mct_pkg::PAGE_CNT))
            cnt_next[addr[5:2]] = wr_data[15:0];
         if (page_hit(addr, mct_pkg::PAGE_GEN))
            gen_next[addr[5:2]] = wr_data[15:0];
      end
      // a flag set in the clearing cycle survives
      ovf_flag_next = (ovf_flag_reg & ~w1c_ovf) | ovf;
      cap_flag_next = (cap_flag_reg & ~w1c_cap) | cap_evt;
      if (rd_stb)
      begin
         if (addr == mct_pkg::ADDR_START)
            rd_next = {20'h0, start_reg};
         else if (addr == mct_pkg::ADDR_STATUS)
            rd_next = {8'h0, cap_flag_reg, ovf_flag_reg};
         else if (addr == mct_pkg::ADDR_IRQEN)
            rd_next = {8'h0, cap_en_reg, ovf_en_reg};
         else if (page_hit(addr, mct_pkg::PAGE_CTRL))
            rd_next = {22'h0, ctrl_reg[addr[5:2]]};
         else if (page_hit(addr, mct_pkg::PAGE_CNT))
            rd_next = {16'h0, cnt_reg[addr[5:2]]};
         else if (page_hit(addr, mct_pkg::PAGE_GEN))
            rd_next = {16'h0, gen_reg[addr[5:2]]};
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         for (int c = 0; c < N; c++)
         begin
            ctrl_reg[c] <= mct_pkg::CTRL_RST;
            cnt_reg[c]  <= mct_pkg::CNT_RST;
            gen_reg[c]  <= mct_pkg::CNT_RST;
         end
         start_reg    <= mct_pkg::START_RST;
         ovf_flag_reg <= mct_pkg::FLAG_RST;
         cap_flag_reg <= mct_pkg::FLAG_RST;
         ovf_en_reg   <= mct_pkg::FLAG_RST;
         cap_en_reg   <= mct_pkg::FLAG_RST;
         rd_reg       <= 32'h0000_0000;
      end
      else
      begin
         for (int c = 0; c < N; c++)
         begin
            ctrl_reg[c] <= ctrl_next[c];
            cnt_reg[c]  <= cnt_next[c];
            gen_reg[c]  <= gen_next[c];
         end
         start_reg    <= start_next;
         ovf_flag_reg <= ovf_flag_next;
         cap_flag_reg <= cap_flag_next;
         ovf_en_reg   <= ovf_en_next;
         cap_en_reg   <= cap_en_next;
         rd_reg       <= rd_next;
      end
   end

   assign rd_data = rd_reg;
   assign ovf_irq = ovf_flag_reg & ovf_en_reg;
   assign irq     = |ovf_irq | |(cap_flag_reg & cap_en_reg);

   // -----------------------------------------------------------
   // checks
   // -----------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   a_start_gate_ch0: assert property (
      !start_reg[0] && !(wr_stb && page_hit(addr, mct_pkg::PAGE_CNT))
      |=> cnt_reg[0] == $past(cnt_reg[0]))
      else $error("counter 0 moved while stopped");
   a_ovf_flag_set: assert property (
      tick[3] && up[3] && cnt_reg[3] == 16'hffff |=> ovf_flag_reg[3] && ovf_irq[3] == ovf_en_reg[3])
      else $error("overflow did not set flag");
   a_wrap_to_zero: assert property (
      tick[3] && up[3] && cnt_reg[3] == 16'hffff
      && !(wr_stb && page_hit(addr, mct_pkg::PAGE_CNT)) |=> cnt_reg[3] == 16'h0000)
      else $error("counter did not wrap to zero");
   a_flag_holds: assert property (
      ovf_flag_reg[3] && !(wr_stb && addr == mct_pkg::ADDR_STATUS) |=> ovf_flag_reg[3])
      else $error("overflow flag dropped without a clear");
   a_irq_follows: assert property (
      ovf_flag_reg[3] && ovf_en_reg[3] |-> irq && ovf_irq[3])
      else $error("interrupt missing with flag and enable set");
   a_capture_copy: assert property (
      cap_evt[2] && !(wr_stb && page_hit(addr, mct_pkg::PAGE_GEN))
      |=> gen_reg[2] == $past(cnt_reg[2]))
      else $error("capture stored the wrong count");
   a_edge_fall_only: assert property (
      ctrl_reg[4].cap_src == mct_pkg::SRC_PIN && ctrl_reg[4].edge_sel == mct_pkg::EDGE_FALL
      && pa_ev[4].rise |-> !cap_evt[4])
      else $error("rising edge captured in falling mode");
   a_phi1_blocked: assert property (
      ctrl_reg[0].cap_src == mct_pkg::SRC_CLK && ctrl_reg[1].clk_sel == mct_pkg::CLK_DIV1
      |-> !cap_evt[0])
      else $error("capture on undivided clock");
   a_cascade_step: assert property (
      ctrl_reg[1].cascade && start_reg[1] && (ovf[2] || unf[2])
      && !(wr_stb && page_hit(addr, mct_pkg::PAGE_CNT))
      |=> cnt_reg[1] == $past(cnt_reg[1]) + ($past(ovf[2]) ? 16'h0001 : 16'hffff))
      else $error("cascade did not step with channel 2");
endmodule : mct_capture_timer
`default_nettype wire

// ### mct_pkg.sv
/*
 mct_pkg: constants, register map and carrier types for the capture timer.
 Assumes one 25 MHz system clock and a plain address/strobe register port.
*/
package mct_pkg;
   localparam int          CH_NUM    = 12;
   localparam int          CNT_W     = 16;
   localparam int          DIV_NUM   = 7;
   localparam int          PRE_W     = 12;
   localparam int          DIV_LOG2 [DIV_NUM] = '{0, 2, 4, 6, 8, 10, 12};

   // -----------------------------------------------------------
   // register map (byte addresses)
   // -----------------------------------------------------------
   localparam logic [7:0]  ADDR_START  = 8'h00;
   localparam logic [7:0]  ADDR_STATUS = 8'h04;
   localparam logic [7:0]  ADDR_IRQEN  = 8'h08;
   localparam logic [1:0]  PAGE_CTRL   = 2'h1;
   localparam logic [1:0]  PAGE_CNT    = 2'h2;
   localparam logic [1:0]  PAGE_GEN    = 2'h3;
   localparam int          STAT_OVF_LSB = 0;
   localparam int          STAT_CAP_LSB = 12;

   // channel groups
   localparam logic [11:0] CAP_OTHER_MASK = 12'h6db;
   localparam logic [11:0] PHI1_BLOCK_MASK = 12'h249;
   localparam logic [11:0] CASCADE_MASK   = 12'h082;

   localparam logic [11:0] START_RST = 12'h000;
   localparam logic [11:0] FLAG_RST  = 12'h000;
   localparam logic [15:0] CNT_RST   = 16'h0000;
   localparam logic [15:0] CNT_MAX   = 16'hffff;

   typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_BOTH, EDGE_OFF} mct_edge_t;
   typedef enum logic [1:0] {SRC_PIN, SRC_CLK, SRC_MATCH, SRC_NONE} mct_src_t;
   typedef enum logic [2:0] {
      CLK_DIV1, CLK_DIV4, CLK_DIV16, CLK_DIV64, CLK_DIV256, CLK_DIV1024, CLK_DIV4096, CLK_STOP
   } mct_clk_t;

   // channel control word, 10 bits, low bits of the ctrl register
   typedef struct packed {
      logic      clr_on_cap;
      logic      phase_mode;
      logic      cascade;
      mct_clk_t  clk_sel;
      mct_src_t  cap_src;
      mct_edge_t edge_sel;
   } mct_ctrl_t;

   localparam mct_ctrl_t CTRL_RST = '{1'b0, 1'b0, 1'b0, CLK_DIV1, SRC_PIN, EDGE_RISE};

   typedef struct packed {
      logic level;
      logic rise;
      logic fall;
   } mct_pin_t;
endpackage : mct_pkg

// ### mct_edge_det.sv
/*
 mct_edge_det: three-stage synchroniser and edge finder for one pin.
 Assumes the pin is asynchronous to ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module mct_edge_det (
   input  wire logic          ref_clk,
   input  wire logic          rst_b,
   input  wire logic          pin_in,
   output mct_pkg::mct_pin_t  pin_ev
);
   logic [2:0] sync_reg;
   logic [2:0] sync_next;
   logic       lvl_reg;
   logic       lvl_next;

   // first stage feeds only the second; a level counts once stages 2 and 3 agree
   always_comb
   begin
      sync_next = {sync_reg[1:0], pin_in};
      lvl_next  = (sync_reg[2] == sync_reg[1]) ? sync_reg[2] : lvl_reg;
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sync_reg <= 3'h0;
         lvl_reg  <= 1'b0;
      end
      else
      begin
         sync_reg <= sync_next;
         lvl_reg  <= lvl_next;
      end
   end

   assign pin_ev.level = lvl_reg;
   assign pin_ev.rise  = lvl_next & ~lvl_reg;
   assign pin_ev.fall  = ~lvl_next & lvl_reg;
endmodule : mct_edge_det
`default_nettype wire

// ### mct_prescale.sv
/*
 mct_prescale: free-running divider giving one-cycle count ticks.
 Assumes ref_clk is the undivided system clock.
*/
`timescale 1ns/100ps
`default_nettype none
module mct_prescale (
   input  wire logic                        ref_clk,
   input  wire logic                        rst_b,
   output logic [mct_pkg::DIV_NUM-1:0]      div_tick
);
   logic [mct_pkg::PRE_W-1:0] pre_reg;
   logic [mct_pkg::PRE_W-1:0] pre_next;

   always_comb
   begin
      pre_next = pre_reg + 12'h001;
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         pre_reg <= 12'h000;
      else
         pre_reg <= pre_next;
   end

   for (genvar k = 0; k < mct_pkg::DIV_NUM; k++)
   begin : g_tick
      localparam logic [mct_pkg::PRE_W:0] MASK = 13'(13'h1 << mct_pkg::DIV_LOG2[k]) - 13'h1;
      assign div_tick[k] = &(pre_reg | ~MASK[mct_pkg::PRE_W-1:0]);
   end
endmodule : mct_prescale
`default_nettype wire

// ### mct_pin_model.sv
/*
 mct_pin_model: outside source of the capture and phase pins.
 Assumes the testbench asks for every pin change through drive().
*/
`timescale 1ns/100ps
`default_nettype none
module mct_pin_model (
   input  wire logic   ref_clk,
   output logic [11:0] pin_a,
   output logic [11:0] pin_b
);
   initial
   begin
      pin_a = 12'h000;
      pin_b = 12'h000;
   end

   // levels move just after an edge; both pin groups change together
   task automatic drive(input logic [11:0] a, input logic [11:0] b);
      @(posedge ref_clk);
      pin_a <= a;
      pin_b <= b;
   endtask : drive
endmodule : mct_pin_model
`default_nettype wire

// ### testbench.sv
/*
 testbench: register-port driver and checks for mct_capture_timer.
 Assumes the pin model is the only source of pin edges.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic        ref_clk;
   logic        rst_b;
   logic [7:0]  addr;
   logic [31:0] wr_data;
   logic        wr_stb;
   logic        rd_stb;
   logic [31:0] rd_data;
   logic [11:0] pin_a;
   logic [11:0] pin_b;
   logic [11:0] ovf_irq;
   logic        irq;
   int          failures;
   int          check_count;
   int          seed;
   int          d;
   logic [31:0] rv;
   logic [31:0] rw;
   logic [15:0] r1;
   logic [15:0] r2;
   logic [15:0] gen_m;

   mct_capture_timer i_mct_capture_timer (.ref_clk(ref_clk), .rst_b(rst_b), .addr(addr),
      .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
      .capture_compare_pin_a(pin_a), .capture_compare_pin_b(pin_b),
      .ovf_irq(ovf_irq), .irq(irq));
   mct_pin_model i_mct_pin_model (.ref_clk(ref_clk), .pin_a(pin_a), .pin_b(pin_b));

   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // ------------------------------------------------------------
   // bus and check tasks
   // ------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      wr_stb  <= 1'b1;
      addr    <= a;
      wr_data <= v;
      @(posedge ref_clk);
      wr_stb  <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge ref_clk);
      rd_stb <= 1'b1;
      addr   <= a;
      @(posedge ref_clk);
      rd_stb <= 1'b0;
      #1 v = rd_data;
   endtask : rd

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out;
      if (failures == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : close_out

   function automatic logic [31:0] ctl(input logic [1:0] e, input logic [1:0] s,
                                       input logic [2:0] c, input logic cas, input logic ph);
      mct_pkg::mct_ctrl_t w;
      w = '{1'b0, ph, cas, mct_pkg::mct_clk_t'(c), mct_pkg::mct_src_t'(s),
            mct_pkg::mct_edge_t'(e)};
      return {22'h0, w};
   endfunction : ctl

   initial
   begin
      repeat (6000) @(posedge ref_clk);
      failures++;
      close_out();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      seed = 32'h0e21d77f;
      failures = 0;
      check_count = 0;
      rst_b = 1'b0;
      addr = 8'h00;
      wr_data = 32'h0;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      repeat (3) @(posedge ref_clk);
      rst_b <= 1'b1;
      rd(mct_pkg::ADDR_START, rv); check(rv, 32'h0);
      rd(8'h40, rv); check(rv, {22'h0, mct_pkg::CTRL_RST});
      rd(8'h0c, rv); check(rv, 32'h0);
      rd(8'h8c, rv); check(rv, 32'h0);
      // running counter: two reads d+2 cycles apart differ by d+2
      wr(mct_pkg::ADDR_START, 32'h008);
      d = $random(seed) & 15;
      rd(8'h8c, rv);
      repeat (d) @(posedge ref_clk);
      rd(8'h8c, rw); check(rw - rv, d + 2);
      wr(mct_pkg::ADDR_START, 32'h0);
      wr(8'h8c, 32'hfff0);
      wr(mct_pkg::ADDR_IRQEN, 32'h008);
      wr(mct_pkg::ADDR_STATUS, 32'hffffff);
      wr(mct_pkg::ADDR_START, 32'h008);
      repeat (30) @(posedge ref_clk);
      check({ovf_irq, irq}, {12'h008, 1'b1});
      rd(mct_pkg::ADDR_STATUS, rv); check(rv, 32'h8);
      rd(8'h8c, rv); check(rv, 32'h11);
      wr(mct_pkg::ADDR_START, 32'h0);
      wr(mct_pkg::ADDR_IRQEN, 32'h0);
      #1 check({ovf_irq, irq}, 13'h0);
      rd(mct_pkg::ADDR_STATUS, rv); check(rv, 32'h8);
      wr(mct_pkg::ADDR_STATUS, 32'h8);
      rd(mct_pkg::ADDR_STATUS, rv); check(rv, 32'h0);
      // every edge mode on a stopped channel: general reg takes the held count
      wr(8'hd0, 32'h0);
      gen_m = 16'h0;
      for (int i = 0; i < 4; i++)
      begin
         r1 = 16'($random(seed));
         r2 = 16'($random(seed));
         wr(8'h50, ctl(i[1:0], mct_pkg::SRC_PIN, mct_pkg::CLK_DIV1, 1'b0, 1'b0));
         wr(8'h90, {16'h0, r1});
         i_mct_pin_model.drive(pin_a | 12'h010, pin_b);
         repeat (6) @(posedge ref_clk);
         if (i == 0 || i == 2)
            gen_m = r1;
         rd(8'hd0, rv); check(rv, {16'h0, gen_m});
         wr(8'h90, {16'h0, r2});
         i_mct_pin_model.drive(pin_a & 12'hfef, pin_b);
         repeat (6) @(posedge ref_clk);
         if (i == 1 || i == 2)
            gen_m = r2;
         rd(8'hd0, rv); check(rv, {16'h0, gen_m});
      end
      // two running channels from equal counts, pins d cycles apart
      wr(8'h50, ctl(2'd0, mct_pkg::SRC_PIN, mct_pkg::CLK_DIV1, 1'b0, 1'b0));
      wr(8'h90, 32'h0);
      wr(8'h94, 32'h0);
      d = 4 + ($random(seed) & 7);
      wr(mct_pkg::ADDR_START, 32'h030);
      i_mct_pin_model.drive(pin_a | 12'h010, pin_b);
      repeat (d - 1) @(posedge ref_clk);
      i_mct_pin_model.drive(pin_a | 12'h020, pin_b);
      repeat (8) @(posedge ref_clk);
      rd(8'hd0, rv);
      rd(8'hd4, rw); check(rw - rv, d);
      // cascade: ch1 upper half, ch2 lower half
      wr(mct_pkg::ADDR_START, 32'h0);
      wr(8'h44, ctl(2'd0, mct_pkg::SRC_PIN, mct_pkg::CLK_DIV1, 1'b1, 1'b0));
      wr(8'h84, {16'h0, r1});
      wr(8'h88, 32'hfff8);
      wr(mct_pkg::ADDR_START, 32'h006);
      repeat (20) @(posedge ref_clk);
      wr(mct_pkg::ADDR_START, 32'h0);
      rd(8'h84, rv); check(rv, {16'h0, r1 + 16'h1});
      wr(8'h88, {16'h0, r2});
      i_mct_pin_model.drive(pin_a | 12'h006, pin_b);
      repeat (6) @(posedge ref_clk);
      rd(8'hc4, rv); check(rv, {16'h0, r1 + 16'h1});
      rd(8'hc8, rv); check(rv, {16'h0, r2});
      // phase mode on ch2: fall with low phase b steps down, rise steps up
      wr(8'h48, ctl(2'd3, mct_pkg::SRC_PIN, mct_pkg::CLK_DIV1, 1'b0, 1'b1));
      wr(8'h88, 32'h0);
      wr(mct_pkg::ADDR_START, 32'h006);
      i_mct_pin_model.drive(pin_a & 12'hffb, 12'h000);
      repeat (6) @(posedge ref_clk);
      rd(8'h84, rv); check(rv, {16'h0, r1});
      rd(8'h88, rv); check(rv, 32'hffff);
      i_mct_pin_model.drive(pin_a | 12'h004, 12'h000);
      repeat (6) @(posedge ref_clk);
      rd(8'h84, rv); check(rv, {16'h0, r1 + 16'h1});
      // other-channel clock source: refused on /1 and on ch2, taken on /4
      wr(mct_pkg::ADDR_START, 32'h0);
      wr(8'h40, ctl(2'd0, mct_pkg::SRC_CLK, mct_pkg::CLK_DIV1, 1'b0, 1'b0));
      wr(8'h44, ctl(2'd3, mct_pkg::SRC_PIN, mct_pkg::CLK_DIV1, 1'b0, 1'b0));
      wr(8'h48, ctl(2'd0, mct_pkg::SRC_CLK, mct_pkg::CLK_DIV1, 1'b0, 1'b0));
      wr(mct_pkg::ADDR_STATUS, 32'hffffff);
      wr(mct_pkg::ADDR_START, 32'h007);
      repeat (10) @(posedge ref_clk);
      rd(mct_pkg::ADDR_STATUS, rv); check(rv[14:12], 3'h0);
      wr(8'h44, ctl(2'd3, mct_pkg::SRC_PIN, mct_pkg::CLK_DIV4, 1'b0, 1'b0));
      wr(mct_pkg::ADDR_STATUS, 32'hfff000);
      repeat (10) @(posedge ref_clk);
      rd(mct_pkg::ADDR_STATUS, rv); check(rv[14:12], 3'h1);
      // compare-match source: ch4 watches ch3
      wr(mct_pkg::ADDR_START, 32'h0);
      wr(8'h50, ctl(2'd0, mct_pkg::SRC_MATCH, mct_pkg::CLK_DIV1, 1'b0, 1'b0));
      wr(8'h8c, 32'h0);
      wr(8'hcc, 32'h10);
      wr(mct_pkg::ADDR_STATUS, 32'hffffff);
      wr(mct_pkg::ADDR_START, 32'h018);
      repeat (30) @(posedge ref_clk);
      rd(mct_pkg::ADDR_STATUS, rv); check(rv[16], 1'b1);
      close_out();
   end
endmodule : testbench
`default_nettype wire
